/* rtl/cfr_pkg.sv */
// Purpose: Shared constants and types of the clock fan-out configuration bank
// Assumes: Serial link is a two-wire bus sampled on its own link clock
// Notes:   Offsets are register indices carried in the command code
package cfr_pkg;

  // ==========================================================================
  // Register map
  localparam logic [6:0] OFS_DRIVE = 7'h00;
  localparam logic [6:0] OFS_SWING = 7'h01;
  localparam logic [6:0] OFS_BANK  = 7'h02;
  localparam logic [6:0] OFS_ID    = 7'h05;
  localparam logic [6:0] OFS_ADDR  = 7'h0e;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_SWING = 8'h00;
  localparam logic [7:0] RST_BANK  = 8'hf1;
  localparam logic [7:0] RST_OEN   = 8'hff;
  // Arbitrary identification value
  localparam logic [7:0] CHIP_ID_DEFAULT = 8'h5a;

  // ==========================================================================
  // Field positions
  localparam int unsigned CMD_BYTE_BIT = 7;
  localparam int unsigned B1_SEL_BIT   = 5;
  localparam int unsigned B0_SEL_BIT   = 4;
  localparam int unsigned B1_MUTE_BIT  = 3;
  localparam int unsigned B0_MUTE_BIT  = 2;
  localparam int unsigned IN1_EN_BIT   = 1;
  localparam int unsigned IN0_EN_BIT   = 0;
  localparam int unsigned BANK_OUTS    = 4;

  // ==========================================================================
  // Bus addressing and bit slots
  localparam logic [6:0] BUS_ADDR_BASE = 7'h68;
  localparam int unsigned BUS_RATE_KHZ = 400;
  localparam logic [3:0] CNT_ACK       = 4'h8;
  localparam logic [3:0] CNT_END       = 4'h9;

  // ==========================================================================
  // Serial engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_CMD  = 6'b000100,
    ST_WR   = 6'b001000,
    ST_RD   = 6'b010000,
    ST_WAIT = 6'b100000
  } cfr_state_t;

endpackage

/* rtl/cfr_config_regs.sv */
// Purpose: Serially programmed configuration bank of an eight-pair clock buffer
// Assumes: linkClk oversamples the bus well above its 400 kHz rate
// Notes:   Registers live on linkClk; a toggle hands each write to core_clk
// Contract
// [RL1] Disabled pair is high impedance; enabled pair drives the clock.
// [RL2] Drive enables sit at offset 0x00, one independent bit per pair.
// [RL3] Enable bit n controls pair n, each bit read and write.
// [RL4] Drive enable register resets to zero, all pairs disabled.
// [RL5] Swing bit per output: 0 standard 350 mV, 1 boosted 500 mV.
// [RL6] Swing select bits sit at offset 0x01.
// [RL7] Command bit 7: 0 block transfer, 1 single-byte transfer.
// [RL8] Command bits 6..0 give the register or starting address.
// [RL9] Direction bit after the bus address: 1 read, 0 write.
// [RL10] Receiver answers each byte: low acknowledges, high refuses.
// [RL11] Start, repeated start and stop delimit every transaction.
// [RL12] Controller leaves reserved locations unmodified; the bench writes 0x55 to offset 0x03.
// [RL13] Input enables and bank settings sit at offset 2h.
// [RL14] Controller programs only permitted bank and input combinations.
// [RL15] Serial interface works at up to the 400 kHz bus rate.
// [RL16] Bus address 0x68 to 0x6B taken from two address straps.
// [RL17] Swing select register resets to zero, standard swing.
// [RL18] Block transfers advance the register address after each byte.
// [RL19] Byte read: command write, repeated start, one byte, refuse, stop.
`timescale 1ns/1ps
module cfr_config_regs
  import cfr_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = cfr_pkg::CHIP_ID_DEFAULT
) (
  // Core clock and control
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  // Serial link
  input  wire logic       linkClk,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOen,
  // Address straps
  input  wire logic       addressStrapLow,
  input  wire logic       addressStrapHigh,
  // Clock inputs
  input  wire logic [1:0] clockIn,
  // Output pairs
  output logic      [7:0] clockOutTrue,
  output logic      [7:0] clockOutComplement,
  output logic      [7:0] clockOutOen,
  output logic      [7:0] swingBoostSelect,
  output logic      [1:0] inputReceiverEnable
);
  import cfr_pkg::*;

  // ==========================================================================
  // Link domain synchronisers
  logic [5:0] lMeta_q;
  logic [5:0] lSync_q;
  logic       sclPrev_q;
  logic       sdaPrev_q;
  logic       linkRstn;
  logic       lEn;
  logic       scl;
  logic       sda;
  logic       sclRise;
  logic       sclFall;
  logic       startC;
  logic       stopC;

  // RL15 oversampled pins
  always_ff @(posedge linkClk) begin
    lMeta_q   <= {resetn, clkEn, sclIn, sdaIn, addressStrapHigh, addressStrapLow};
    lSync_q   <= lMeta_q;
    sclPrev_q <= lSync_q[3];
    sdaPrev_q <= lSync_q[2];
  end

  assign linkRstn = lSync_q[5];
  assign lEn      = lSync_q[4];
  assign scl      = lSync_q[3];
  assign sda      = lSync_q[2];
  assign sclRise  = scl & ~sclPrev_q;
  assign sclFall  = ~scl & sclPrev_q;
  // RL11 bus delimiters
  assign startC   = scl & sclPrev_q & sdaPrev_q & ~sda;
  assign stopC    = scl & sclPrev_q & ~sdaPrev_q & sda;

  // ==========================================================================
  // Serial engine and registers
  cfr_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [6:0] ptr_q, ptr_d;
  logic       byteMode_q, byteMode_d;
  logic [7:0] rdByte_q, rdByte_d;
  logic       sdaDrv_q, sdaDrv_d;
  logic [7:0] r0_q, r0_d;
  logic [7:0] r1_q, r1_d;
  logic [7:0] r2_q, r2_d;
  logic [6:0] devAddr_q;
  logic       wrTgl_q, wrTgl_d;
  logic       wrEn;
  logic [7:0] txSh;

  // Register read decode
  function automatic logic [7:0] regRead(input logic [6:0] p, input logic [7:0] d0,
                                         input logic [7:0] d1, input logic [7:0] d2,
                                         input logic [6:0] a);
    case (p)
      OFS_DRIVE: regRead = d0;
      OFS_SWING: regRead = d1;
      OFS_BANK:  regRead = d2;
      OFS_ID:    regRead = CHIP_ID;
      OFS_ADDR:  regRead = {1'b0, a};
      default:   regRead = 8'h00;
    endcase
  endfunction

  assign txSh = rdByte_q << cnt_q;

  // Next state of the serial engine
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    shift_d    = shift_q;
    ptr_d      = ptr_q;
    byteMode_d = byteMode_q;
    rdByte_d   = rdByte_q;
    sdaDrv_d   = sdaDrv_q;
    r0_d       = r0_q;
    r1_d       = r1_q;
    r2_d       = r2_q;
    wrTgl_d    = wrTgl_q;
    wrEn       = 1'b0;
    if (startC) begin
      state_d  = ST_ADDR;
      cnt_d    = 4'h0;
      sdaDrv_d = 1'b0;
    end else if (stopC) begin
      state_d  = ST_IDLE;
      cnt_d    = 4'h0;
      sdaDrv_d = 1'b0;
    end else if (sclRise && state_q != ST_IDLE && state_q != ST_WAIT) begin
      if (cnt_q < CNT_END) cnt_d = 4'(cnt_q + 4'h1);
      if (cnt_q < CNT_ACK && state_q != ST_RD) begin
        shift_d = {shift_q[6:0], sda};
      end else if (state_q == ST_RD && cnt_q == CNT_ACK) begin
        // RL10 controller refusal ends the read
        if (sda) begin
          state_d = ST_WAIT;
        end else if (!byteMode_q) begin
          // RL18 read address advance
          ptr_d = 7'(ptr_q + 7'h01);
        end
      end
    end else if (sclFall) begin
      case (state_q)
        ST_ADDR: begin
          if (cnt_q == CNT_ACK) begin
            // RL10 address acknowledge
            if (shift_q[7:1] == devAddr_q) sdaDrv_d = 1'b1;
            else state_d = ST_WAIT;
          end else if (cnt_q == CNT_END) begin
            cnt_d    = 4'h0;
            sdaDrv_d = 1'b0;
            // RL9 direction bit
            if (shift_q[0]) begin
              state_d  = ST_RD;
              rdByte_d = regRead(ptr_q, r0_q, r1_q, r2_q, devAddr_q);
              sdaDrv_d = ~rdByte_d[7];
            end else begin
              state_d = ST_CMD;
            end
          end
        end
        ST_CMD: begin
          if (cnt_q == CNT_ACK) begin
            // RL7 RL8 command decode
            sdaDrv_d   = 1'b1;
            byteMode_d = shift_q[CMD_BYTE_BIT];
            ptr_d      = shift_q[6:0];
          end else if (cnt_q == CNT_END) begin
            cnt_d    = 4'h0;
            sdaDrv_d = 1'b0;
            state_d  = ST_WR;
          end
        end
        ST_WR: begin
          if (cnt_q == CNT_ACK) begin
            sdaDrv_d = 1'b1;
            wrEn     = 1'b1;
            // RL18 write address advance
            if (!byteMode_q) ptr_d = 7'(ptr_q + 7'h01);
            // RL2 RL6 RL13 writable offsets only
            case (ptr_q)
              OFS_DRIVE: r0_d = shift_q;
              OFS_SWING: r1_d = shift_q;
              OFS_BANK:  r2_d = shift_q;
              default:   ;
            endcase
            wrTgl_d = ~wrTgl_q;
          end else if (cnt_q == CNT_END) begin
            cnt_d    = 4'h0;
            sdaDrv_d = 1'b0;
          end
        end
        ST_RD: begin
          if (cnt_q < CNT_ACK) begin
            sdaDrv_d = ~txSh[7];
          end else if (cnt_q == CNT_ACK) begin
            sdaDrv_d = 1'b0;
          end else begin
            cnt_d    = 4'h0;
            rdByte_d = regRead(ptr_q, r0_q, r1_q, r2_q, devAddr_q);
            sdaDrv_d = ~rdByte_d[7];
          end
        end
        default: ;
      endcase
    end
  end

  // Link registers
  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 4'h0;
      shift_q    <= 8'h00;
      ptr_q      <= 7'h00;
      byteMode_q <= 1'b0;
      rdByte_q   <= 8'h00;
      sdaDrv_q   <= 1'b0;
      // RL4 RL17 reset values
      r0_q       <= RST_DRIVE;
      r1_q       <= RST_SWING;
      r2_q       <= RST_BANK;
      wrTgl_q    <= 1'b0;
      // RL16 strap capture
      devAddr_q  <= BUS_ADDR_BASE | {5'h00, lSync_q[1:0]};
    end else if (lEn) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      shift_q    <= shift_d;
      ptr_q      <= ptr_d;
      byteMode_q <= byteMode_d;
      rdByte_q   <= rdByte_d;
      sdaDrv_q   <= sdaDrv_d;
      r0_q       <= r0_d;
      r1_q       <= r1_d;
      r2_q       <= r2_d;
      wrTgl_q    <= wrTgl_d;
    end
  end

  // Open-drain data pin
  assign sdaOut = 1'b0;
  assign sdaOen = ~sdaDrv_q;

  // ==========================================================================
  // Core domain capture and output pairs
  logic [2:0] cMeta_q;
  logic [2:0] cSync_q;
  logic       tglSeen_q, tglSeen_d;
  logic       capture;
  logic [7:0] cEn_q, cEn_d;
  logic [7:0] cSw_q, cSw_d;
  logic [7:0] cBank_q, cBank_d;
  logic [7:0] true_d, oen_d;
  logic       src;
  logic       mute;

  // Toggle and clock pin synchronisers
  always_ff @(posedge core_clk) begin
    cMeta_q <= {wrTgl_q, clockIn};
    cSync_q <= cMeta_q;
  end

  assign capture = cSync_q[2] ^ tglSeen_q;

  // Next configuration copy and pair drive
  always_comb begin
    tglSeen_d = cSync_q[2];
    cEn_d     = capture ? r0_q : cEn_q;
    cSw_d     = capture ? r1_q : cSw_q;
    cBank_d   = capture ? r2_q : cBank_q;
    src       = 1'b0;
    mute      = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < BANK_OUTS) begin
        src  = cBank_q[B0_SEL_BIT] ? (cSync_q[0] & cBank_q[IN0_EN_BIT])
                                   : (cSync_q[1] & cBank_q[IN1_EN_BIT]);
        mute = cBank_q[B0_MUTE_BIT];
      end else begin
        src  = cBank_q[B1_SEL_BIT] ? (cSync_q[0] & cBank_q[IN0_EN_BIT])
                                   : (cSync_q[1] & cBank_q[IN1_EN_BIT]);
        mute = cBank_q[B1_MUTE_BIT];
      end
      true_d[i] = src & ~mute;
      // RL1 RL3 pair n follows bit n
      oen_d[i]  = ~cEn_q[i];
    end
  end

  // Core registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tglSeen_q           <= cSync_q[2];
      cEn_q               <= RST_DRIVE;
      cSw_q               <= RST_SWING;
      cBank_q             <= RST_BANK;
      clockOutTrue        <= 8'h00;
      clockOutComplement  <= 8'hff;
      clockOutOen         <= RST_OEN;
      swingBoostSelect    <= RST_SWING;
      inputReceiverEnable <= RST_BANK[1:0];
    end else if (clkEn) begin
      tglSeen_q           <= tglSeen_d;
      cEn_q               <= cEn_d;
      cSw_q               <= cSw_d;
      cBank_q             <= cBank_d;
      clockOutTrue        <= true_d;
      clockOutComplement  <= ~true_d;
      clockOutOen         <= oen_d;
      // RL5 swing per output
      swingBoostSelect    <= cSw_q;
      inputReceiverEnable <= cBank_q[1:0];
    end
  end

  // ==========================================================================
  // Assertions
  hizFollow_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL1
    clkEn |=> clockOutOen == ~$past(cEn_q)) else $error("pair drive mismatch");
  driveCopy_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL2
    capture && clkEn |=> cEn_q == r0_q) else $error("enable copy lost");
  driveReset_a: assert property (@(posedge core_clk) // RL4
    !resetn |=> cEn_q == RST_DRIVE && clockOutOen == RST_OEN) else $error("enable reset");
  swingReset_a: assert property (@(posedge core_clk) // RL17
    !resetn |=> swingBoostSelect == RST_SWING) else $error("swing reset");
  swingPath_a: assert property (@(posedge core_clk) disable iff (!resetn) // RL5
    capture && clkEn ##1 clkEn |=> swingBoostSelect == r1_q) else $error("swing path");
  addrAck_a: assert property (@(posedge linkClk) disable iff (!linkRstn) // RL10
    lEn && sclFall && !startC && state_q == ST_ADDR && cnt_q == CNT_ACK
    && shift_q[7:1] == devAddr_q |=> !sdaOen) else $error("no address acknowledge");
  strapAddr_a: assert property (@(posedge linkClk) // RL16
    !linkRstn |=> devAddr_q == (BUS_ADDR_BASE | {5'h00, $past(lSync_q[1:0])}))
    else $error("strap address");
  cmdDecode_a: assert property (@(posedge linkClk) disable iff (!linkRstn) // RL7
    lEn && sclFall && state_q == ST_CMD && cnt_q == CNT_ACK |=>
    byteMode_q == $past(shift_q[7]) && ptr_q == $past(shift_q[6:0])) else $error("command");
  readDir_a: assert property (@(posedge linkClk) disable iff (!linkRstn) // RL9
    lEn && sclFall && state_q == ST_ADDR && cnt_q == CNT_END |=>
    state_q == ($past(shift_q[0]) ? ST_RD : ST_CMD)) else $error("direction");
  writeDrive_a: assert property (@(posedge linkClk) disable iff (!linkRstn) // RL3
    lEn && wrEn && ptr_q == OFS_DRIVE |=> r0_q == $past(shift_q)) else $error("r0 write");
  writeBank_a: assert property (@(posedge linkClk) disable iff (!linkRstn) // RL13
    lEn && wrEn && ptr_q == OFS_BANK |=> r2_q == $past(shift_q)) else $error("r2 write");
  blockInc_a: assert property (@(posedge linkClk) disable iff (!linkRstn) // RL18
    lEn && wrEn && !byteMode_q |=> ptr_q == 7'($past(ptr_q) + 7'h01)) else $error("advance");
  stopIdle_a: assert property (@(posedge linkClk) disable iff (!linkRstn) // RL11
    lEn && stopC && !startC |=> state_q == ST_IDLE) else $error("stop not idle");

  writeSeen_c: cover property (@(posedge linkClk) disable iff (!linkRstn)
    lEn && wrEn && ptr_q == OFS_DRIVE);
  readSeen_c: cover property (@(posedge linkClk) disable iff (!linkRstn)
    lEn && sclFall && state_q == ST_RD && cnt_q == CNT_END);
  blockSeen_c: cover property (@(posedge linkClk) disable iff (!linkRstn)
    lEn && wrEn && !byteMode_q ##[1:400] lEn && wrEn);
  pairOn_c: cover property (@(posedge core_clk) disable iff (!resetn) !clockOutOen[0]);

endmodule

/* dv/cfr_bus_host.sv */
// Purpose: Two-wire bus controller model facing the configuration bank
// Assumes: Data line has a pull-up; this model alone drives the bus clock
// Notes:   Quarter bit is Q core clocks, near 390 kHz at 25 MHz
`timescale 1ns/1ps
module cfr_bus_host #(
  parameter int Q = 16
) (
  // Clock
  input  wire logic core_clk,
  // Device side of the data line
  input  wire logic sdaOut,
  input  wire logic sdaOen,
  // Bus wires
  output logic      sclLine,
  output logic      sdaLine
);
  // ==========
  // Wire levels
  logic hostLow;
  initial begin
    sclLine = 1'b1;
    hostLow = 1'b0;
  end
  // Open drain, pull-up wins when nobody pulls
  assign sdaLine = !hostLow && (sdaOen || sdaOut);

  // ==========
  // Bus phases
  task automatic qwait(input int n);
    repeat (n * Q) @(posedge core_clk);
  endtask
  task automatic start_cond();
    hostLow <= 1'b0;
    qwait(1);
    sclLine <= 1'b1;
    qwait(2);
    hostLow <= 1'b1;
    qwait(2);
    sclLine <= 1'b0;
    qwait(1);
  endtask
  task automatic stop_cond();
    hostLow <= 1'b1;
    qwait(1);
    sclLine <= 1'b1;
    qwait(2);
    hostLow <= 1'b0;
    qwait(2);
  endtask
  // Data changes only while the clock is low
  task automatic put_bit(input logic b);
    hostLow <= !b;
    qwait(1);
    sclLine <= 1'b1;
    qwait(2);
    sclLine <= 1'b0;
    qwait(1);
  endtask
  // Line released, sampled mid-high
  task automatic get_bit(output logic b);
    hostLow <= 1'b0;
    qwait(1);
    sclLine <= 1'b1;
    qwait(1);
    b = sdaLine;
    qwait(1);
    sclLine <= 1'b0;
    qwait(1);
  endtask
  // Byte out, most significant first, then the answer slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(nack);
  endtask
endmodule

/* dv/cfr_config_regs_test.sv */
// Purpose: Self-checking bench of the clock fan-out configuration bank
// Assumes: Straps give bus address 0x6a; link clock 64 ns
// Notes:   Each scenario task drives the bank and judges the result
`timescale 1ns/1ps
module cfr_config_regs_test;
  import cfr_pkg::*;
  // ==========
  // Signals
  localparam logic [6:0] DEV = 7'h6a;
  logic       core_clk;
  logic       resetn;
  logic       clkEn;
  logic       linkClk;
  logic       sclIn;
  logic       sdaIn;
  logic       sdaOut;
  logic       sdaOen;
  logic       strapLo;
  logic       strapHi;
  logic [1:0] clockIn;
  logic [7:0] clockOutTrue;
  logic [7:0] clockOutComplement;
  logic [7:0] clockOutOen;
  logic [7:0] swingBoostSelect;
  logic [1:0] inputReceiverEnable;
  int         fails;
  int         checked;

  cfr_config_regs dut (
    .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .linkClk(linkClk),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOen(sdaOen),
    .addressStrapLow(strapLo), .addressStrapHigh(strapHi), .clockIn(clockIn),
    .clockOutTrue(clockOutTrue), .clockOutComplement(clockOutComplement),
    .clockOutOen(clockOutOen), .swingBoostSelect(swingBoostSelect),
    .inputReceiverEnable(inputReceiverEnable)
  );
  cfr_bus_host host (
    .core_clk(core_clk), .sdaOut(sdaOut), .sdaOen(sdaOen),
    .sclLine(sclIn), .sdaLine(sdaIn)
  );

  // ==========
  // Clocks
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  // Link clock, phase unrelated to core
  initial begin
    linkClk = 1'b0;
    #7;
    forever #32 linkClk = ~linkClk;
  end

  // ==========
  // Checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========
  // Bus transfers
  task automatic send_b(input logic [7:0] d);
    logic ack;
    host.wbyte(d, ack);
    check({7'h00, ack}, 8'h00);
  endtask
  task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] d [$]);
    host.start_cond();
    send_b({DEV, 1'b0});
    send_b(cmd);
    foreach (d[i]) send_b(d[i]);
    host.stop_cond();
  endtask
  task automatic reg_rd(input logic [7:0] cmd, input int n, output logic [7:0] q [$]);
    logic [7:0] b;
    q = {};
    host.start_cond();
    send_b({DEV, 1'b0});
    send_b(cmd);
    // repeated start, read, refuse last byte
    host.start_cond();
    send_b({DEV, 1'b1});
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, b);
      q.push_back(b);
    end
    host.stop_cond();
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] q [$];
    reg_rd(cmd, 1, q);
    check(q[0], exp);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    check(clockOutOen, 8'hff);
    check(clockOutTrue, 8'h00);
    check(swingBoostSelect, 8'h00);
    check({6'h00, inputReceiverEnable}, 8'h01);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h81, 8'h00);
    rd_chk(8'h82, RST_BANK);
  endtask
  task automatic t_address();
    logic ack;
    host.start_cond();
    host.wbyte({BUS_ADDR_BASE, 1'b0}, ack);
    host.stop_cond();
    check({7'h00, ack}, 8'h01);
    rd_chk({1'b1, OFS_ADDR}, {1'b0, DEV});
    rd_chk({1'b1, OFS_ID}, CHIP_ID_DEFAULT);
  endtask
  task automatic t_byte_mode();
    reg_wr(8'h80, '{8'ha5});
    check(clockOutOen, 8'h5a);
    rd_chk(8'h80, 8'ha5);
    reg_wr(8'h81, '{8'h3c, 8'h96});
    check(swingBoostSelect, 8'h96);
    check(clockOutOen, 8'h5a);
    rd_chk(8'h81, 8'h96);
    rd_chk(8'h82, RST_BANK);
  endtask
  task automatic t_block_mode();
    logic [7:0] q [$];
    // both banks on IN1 with IN1 enabled
    reg_wr(8'h00, '{8'h0f, 8'hf0, 8'hc3});
    check(clockOutOen, 8'hf0);
    check(swingBoostSelect, 8'hf0);
    check({6'h00, inputReceiverEnable}, 8'h03);
    reg_rd(8'h00, 3, q);
    check(q[0], 8'h0f);
    check(q[1], 8'hf0);
    check(q[2], 8'hc3);
  endtask
  task automatic t_pairs();
    clockIn <= 2'b10;
    repeat (8) @(posedge core_clk);
    check(clockOutTrue & ~clockOutOen, 8'h0f);
    check(clockOutComplement, 8'h00);
    // bank 0 muted, all pairs on
    reg_wr(8'h82, '{8'hc7});
    reg_wr(8'h80, '{8'hff});
    check(clockOutTrue, 8'hf0);
    clockIn <= 2'b00;
    repeat (8) @(posedge core_clk);
    check(clockOutTrue, 8'h00);
  endtask
  task automatic t_reserved();
    // deliberate writes to unlisted and read-only places
    reg_wr(8'h83, '{8'h55});
    rd_chk(8'h83, 8'h00);
    reg_wr(8'h85, '{8'h00});
    rd_chk(8'h85, CHIP_ID_DEFAULT);
    check(clockOutOen, 8'h00);
  endtask
  // Reset again in mid-run, all state back to defaults
  task automatic t_midreset();
    resetn <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge core_clk);
    check(clockOutOen, 8'hff);
    check(clockOutTrue, 8'h00);
    check(swingBoostSelect, 8'h00);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h81, 8'h00);
  endtask

  // ==========
  // Main sequence
  initial begin
    fails = 0;
    checked = 0;
    resetn = 1'b0;
    clkEn = 1'b1;
    strapLo = 1'b0;
    strapHi = 1'b1;
    clockIn = 2'b00;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge core_clk);
    t_reset();
    t_address();
    t_byte_mode();
    t_block_mode();
    t_pairs();
    t_reserved();
    t_midreset();
    finish_test();
  end
  // Watchdog
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    finish_test();
  end
endmodule
